// *** pkg/i2c_scs_pkg.sv ***
/*
 * Constants, register map and state type of the I2C start, division
 * clock and shift block.
 * Assumes a 32-bit APB slave with byte addresses in paddr[7:0].
 */
`default_nettype none
package i2c_scs_pkg;
	////////////////////////////////////////////////////////////////////////
	// Register byte addresses
	localparam logic [7:0] ADDR_PRESC = 8'h00;
	localparam logic [7:0] ADDR_SHIFT = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_FLAG = 8'h0C;
	localparam logic [7:0] ADDR_IRQ = 8'h10;
	localparam logic [7:0] ADDR_MASK = 8'h14;
	////////////////////////////////////////////////////////////////////////
	// Prescaler fields
	localparam int PRESC_EN_BIT = 4;
	localparam int PRESC_BYP_BIT = 3;
	localparam logic [7:0] PRESC_RW_MASK = 8'h1B;
	localparam logic [7:0] PRESC_RESET = 8'h00;
	localparam logic [7:0] SHIFT_RESET = 8'h00;
	////////////////////////////////////////////////////////////////////////
	// Control and flag fields
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_EXIT = 2;
	localparam int CTRL_ENABLE = 3;
	localparam int CTRL_RSV_DIS = 4;
	localparam int FLAG_STCF = 0;
	localparam int FLAG_BUSY = 1;
	localparam int FLAG_WAIT = 2;
	localparam int FLAG_MASTER = 3;
	////////////////////////////////////////////////////////////////////////
	// Interrupt status bits
	localparam int IRQ_W = 3;
	localparam int IRQ_START = 0;
	localparam int IRQ_BYTE = 1;
	localparam int IRQ_STCF = 2;
	////////////////////////////////////////////////////////////////////////
	// Timing in division clock ticks
	localparam logic [3:0] HOLD_TICKS = 4'h4;
	localparam logic [3:0] PHASE_TICKS = 4'h4;
	localparam logic [2:0] LAST_BIT = 3'h7;
	////////////////////////////////////////////////////////////////////////
	typedef enum logic [3:0] {
		ST_IDLE, ST_START_HOLD, ST_WAIT, ST_SHIFT_LOW, ST_SHIFT_HIGH,
		ST_RESTART_LOW, ST_RESTART_HIGH, ST_STOP_LOW, ST_STOP_HIGH
	} state_e;

	// Last count of the divider: divide by select+2, or by 1 on bypass
	function automatic logic [2:0] div_last(input logic bypass,
		input logic [1:0] select);
		div_last = bypass ? 3'h0 : {1'b0, select} + 3'h1;
	endfunction : div_last
endpackage : i2c_scs_pkg
`default_nettype wire

// *** src/i2c_prescaler.sv ***
/*
 * Division clock generator: one-cycle tick every div_last+1 cycles.
 * Assumes enable, bypass and select come from a register on clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none
module i2c_prescaler (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Settings
	input wire logic enable,
	input wire logic bypass,
	input wire logic [1:0] select,
	// Division clock
	output logic tick
);
	logic [2:0] cnt;
	logic [2:0] last;

	always_comb
	begin
		last = i2c_scs_pkg::div_last(bypass, select);
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt <= 3'h0;
			tick <= 1'b0;
		end
		else if (!enable)
		begin
			cnt <= 3'h0;
			tick <= 1'b0;
		end
		else if (cnt >= last)
		begin
			cnt <= 3'h0;
			tick <= 1'b1;
		end
		else
		begin
			cnt <= cnt + 3'h1;
			tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	div_stop_a: assert property (!enable |=> !tick)
		else $error("division clock ticks while disabled");
	div_bypass_a: assert property (
		enable && bypass ##1 enable && bypass |=> tick)
		else $error("bypass does not tick every cycle");
	div_five_a: assert property (
		enable && !bypass && select == 2'h3 && tick ##1
		(enable && !bypass && select == 2'h3) [*4] |=> tick)
		else $error("divide by five period wrong");
endmodule : i2c_prescaler
`default_nettype wire

// *** src/i2c_shifter.sv ***
/*
 * Eight-bit shift register, MSB first out, sample into the LSB.
 * Assumes load and shift are never asserted together.
 */
`timescale 1ns/100ps
`default_nettype none
module i2c_shifter (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Control
	input wire logic load,
	input wire logic [7:0] load_data,
	input wire logic shift,
	input wire logic shift_in,
	// Contents
	output logic [7:0] data
);
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			data <= i2c_scs_pkg::SHIFT_RESET;
		else if (load)
			data <= load_data;
		else if (shift)
			data <= {data[6:0], shift_in};
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	shift_step_a: assert property (
		shift && !load |=> data == {$past(data[6:0]), $past(shift_in)})
		else $error("shift register did not shift");
endmodule : i2c_shifter
`default_nettype wire

// *** src/i2c_start_clock_shift.sv ***
/*
 * I2C start trigger with reservation, division clock and shift register,
 * with an APB register slave and a level interrupt.
 * Assumes open-drain pins outside; oe_b low pulls the line low.
 */
// Chosen here: the APB register port and the register addresses.
// Operation
// - A start on a free bus pulls data low with clock high, then after the hold time pulls clock low and waits.
// - With reservation enabled and a busy bus, the trigger waits and starts automatically once the bus is free.
// - With reservation disabled and a busy bus, a start write sets the start-clear flag and no start follows.
// - A start write while master in the wait state releases the wait and makes a repeated start.
// - While the start trigger is 1 a further write of 1 does nothing.
// - The device clears the start trigger once it has made the start; only software sets it.
// - Exit-communication written 1 or operation-enable falling clears the start trigger.
// - Division clock enable bit 4 stops the division clock at 0 and runs it at 1.
// - Select codes 00 to 11 divide by 2 to 5, and bypass uses the undivided clock.
// - The 8-bit shift register shifts with the serial clock and resets to zero.
// - A shift register write in the wait state ends the wait and shifts the byte out.
`timescale 1ns/100ps
`default_nettype none
module i2c_start_clock_shift (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Bus lines
	input wire logic bus_data_line_i,
	output logic bus_data_line_o,
	output logic bus_data_line_oe_b,
	input wire logic bus_clock_line_i,
	output logic bus_clock_line_o,
	output logic bus_clock_line_oe_b,
	// Interrupt
	output logic irq
);
	localparam int IRQ_HI = i2c_scs_pkg::IRQ_W - 1;
	i2c_scs_pkg::state_e state;
	logic [7:0] prescaler_register;
	logic start_trigger, stop_trigger, operation_enable;
	logic reservation_disable, start_clear_flag, bus_busy, pending_go;
	logic [IRQ_HI:0] irq_status, irq_mask;
	logic [2:0] sda_sync, scl_sync;
	logic sda_f, scl_f, sda_prev, scl_prev;
	logic [3:0] cnt;
	logic [2:0] bit_cnt;
	logic tick, phase_end, hold_done, byte_done;
	logic setup, acc, ctl_wr, sh_wr, sw_start, deny, en_fall, exit_wr;
	logic loadable, shift_en;
	logic [7:0] shift_data;
	logic [IRQ_HI:0] ev;

	////////////////////////////////////////////////////////////////////////
	// Sub-blocks
	i2c_prescaler u_presc (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.enable(prescaler_register[i2c_scs_pkg::PRESC_EN_BIT]),
		.bypass(prescaler_register[i2c_scs_pkg::PRESC_BYP_BIT]),
		.select(prescaler_register[1:0]),
		.tick(tick)
	);

	i2c_shifter u_shift (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.load(sh_wr && loadable),
		.load_data(pwdata[7:0]),
		.shift(shift_en),
		.shift_in(sda_f),
		.data(shift_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Decode
	always_comb
	begin
		setup = psel && !penable;
		acc = psel && penable && pready;
		ctl_wr = acc && pwrite && paddr == i2c_scs_pkg::ADDR_CTRL;
		sh_wr = acc && pwrite && paddr == i2c_scs_pkg::ADDR_SHIFT;
		sw_start = ctl_wr && pwdata[i2c_scs_pkg::CTRL_START]
			&& !start_trigger;
		deny = sw_start && bus_busy && reservation_disable
			&& state == i2c_scs_pkg::ST_IDLE;
		exit_wr = ctl_wr && pwdata[i2c_scs_pkg::CTRL_EXIT];
		en_fall = ctl_wr && operation_enable
			&& !pwdata[i2c_scs_pkg::CTRL_ENABLE];
		phase_end = tick && cnt == ((state == i2c_scs_pkg::ST_START_HOLD)
			? i2c_scs_pkg::HOLD_TICKS : i2c_scs_pkg::PHASE_TICKS) - 4'h1;
		hold_done = phase_end && state == i2c_scs_pkg::ST_START_HOLD;
		byte_done = phase_end && state == i2c_scs_pkg::ST_SHIFT_HIGH
			&& bit_cnt == i2c_scs_pkg::LAST_BIT;
		shift_en = phase_end && state == i2c_scs_pkg::ST_SHIFT_HIGH;
		loadable = state != i2c_scs_pkg::ST_SHIFT_LOW
			&& state != i2c_scs_pkg::ST_SHIFT_HIGH;
		ev = '0;
		ev[i2c_scs_pkg::IRQ_START] = hold_done;
		ev[i2c_scs_pkg::IRQ_BYTE] = byte_done;
		ev[i2c_scs_pkg::IRQ_STCF] = deny;
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and bus monitor
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sda_sync <= 3'h7;
			scl_sync <= 3'h7;
			sda_f <= 1'b1;
			scl_f <= 1'b1;
		end
		else
		begin
			sda_sync <= {sda_sync[1:0], bus_data_line_i};
			scl_sync <= {scl_sync[1:0], bus_clock_line_i};
			if (sda_sync[1] == sda_sync[2])
				sda_f <= sda_sync[2];
			if (scl_sync[1] == scl_sync[2])
				scl_f <= scl_sync[2];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sda_prev <= 1'b1;
			scl_prev <= 1'b1;
			bus_busy <= 1'b0;
		end
		else
		begin
			sda_prev <= sda_f;
			scl_prev <= scl_f;
			if (scl_f && scl_prev && sda_prev && !sda_f
				&& state == i2c_scs_pkg::ST_IDLE)
				bus_busy <= 1'b1;
			else if (scl_f && scl_prev && !sda_prev && sda_f)
				bus_busy <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			start_trigger <= 1'b0;
			stop_trigger <= 1'b0;
			operation_enable <= 1'b0;
			reservation_disable <= 1'b0;
		end
		else
		begin
			if (ctl_wr)
			begin
				operation_enable <= pwdata[i2c_scs_pkg::CTRL_ENABLE];
				reservation_disable <= pwdata[i2c_scs_pkg::CTRL_RSV_DIS];
			end
			if (sw_start && !deny)
				start_trigger <= 1'b1;
			if (hold_done)
				start_trigger <= 1'b0;
			if (exit_wr || en_fall || deny)
				start_trigger <= 1'b0;
			if (ctl_wr && pwdata[i2c_scs_pkg::CTRL_STOP]
				&& !pwdata[i2c_scs_pkg::CTRL_START])
				stop_trigger <= 1'b1;
			if (state == i2c_scs_pkg::ST_STOP_LOW || exit_wr || en_fall)
				stop_trigger <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			start_clear_flag <= 1'b0;
		else if (deny)
			start_clear_flag <= 1'b1;
		else if (sw_start)
			start_clear_flag <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			prescaler_register <= i2c_scs_pkg::PRESC_RESET;
		else if (acc && pwrite && paddr == i2c_scs_pkg::ADDR_PRESC)
			prescaler_register <= pwdata[7:0]
				& i2c_scs_pkg::PRESC_RW_MASK;
	end

	////////////////////////////////////////////////////////////////////////
	// Bus sequencer
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			cnt <= 4'h0;
		else if (phase_end || state == i2c_scs_pkg::ST_IDLE
			|| state == i2c_scs_pkg::ST_WAIT)
			cnt <= 4'h0;
		else if (tick)
			cnt <= cnt + 4'h1;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			pending_go <= 1'b0;
		else if (state == i2c_scs_pkg::ST_WAIT || !operation_enable)
			pending_go <= 1'b0;
		else if (sh_wr && loadable && start_trigger)
			pending_go <= 1'b1;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= i2c_scs_pkg::ST_IDLE;
			bit_cnt <= 3'h0;
		end
		else if (!operation_enable || exit_wr || en_fall)
			state <= i2c_scs_pkg::ST_IDLE;
		else
		begin
			unique case (state)
				i2c_scs_pkg::ST_IDLE:
					if (start_trigger && !bus_busy)
						state <= i2c_scs_pkg::ST_START_HOLD;
				i2c_scs_pkg::ST_START_HOLD:
					if (hold_done)
						state <= i2c_scs_pkg::ST_WAIT;
				i2c_scs_pkg::ST_WAIT:
					if (start_trigger)
						state <= i2c_scs_pkg::ST_RESTART_LOW;
					else if (sh_wr || pending_go)
					begin
						state <= i2c_scs_pkg::ST_SHIFT_LOW;
						bit_cnt <= 3'h0;
					end
					else if (stop_trigger)
						state <= i2c_scs_pkg::ST_STOP_LOW;
				i2c_scs_pkg::ST_SHIFT_LOW:
					if (phase_end)
						state <= i2c_scs_pkg::ST_SHIFT_HIGH;
				i2c_scs_pkg::ST_SHIFT_HIGH:
					if (byte_done)
						state <= i2c_scs_pkg::ST_WAIT;
					else if (phase_end)
					begin
						state <= i2c_scs_pkg::ST_SHIFT_LOW;
						bit_cnt <= bit_cnt + 3'h1;
					end
				i2c_scs_pkg::ST_RESTART_LOW:
					if (phase_end)
						state <= i2c_scs_pkg::ST_RESTART_HIGH;
				i2c_scs_pkg::ST_RESTART_HIGH:
					if (phase_end)
						state <= i2c_scs_pkg::ST_START_HOLD;
				i2c_scs_pkg::ST_STOP_LOW:
					if (phase_end)
						state <= i2c_scs_pkg::ST_STOP_HIGH;
				i2c_scs_pkg::ST_STOP_HIGH:
					if (phase_end)
						state <= i2c_scs_pkg::ST_IDLE;
				default:
					state <= i2c_scs_pkg::ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bus_data_line_o <= 1'b0;
			bus_clock_line_o <= 1'b0;
			bus_data_line_oe_b <= 1'b1;
			bus_clock_line_oe_b <= 1'b1;
		end
		else
		begin
			bus_data_line_o <= 1'b0;
			bus_clock_line_o <= 1'b0;
			unique case (state)
				i2c_scs_pkg::ST_START_HOLD, i2c_scs_pkg::ST_WAIT,
				i2c_scs_pkg::ST_STOP_LOW, i2c_scs_pkg::ST_STOP_HIGH:
					bus_data_line_oe_b <= 1'b0;
				i2c_scs_pkg::ST_SHIFT_LOW, i2c_scs_pkg::ST_SHIFT_HIGH:
					bus_data_line_oe_b <= shift_data[7];
				default:
					bus_data_line_oe_b <= 1'b1;
			endcase
			bus_clock_line_oe_b <= !(state == i2c_scs_pkg::ST_WAIT
				|| state == i2c_scs_pkg::ST_SHIFT_LOW
				|| state == i2c_scs_pkg::ST_RESTART_LOW
				|| state == i2c_scs_pkg::ST_STOP_LOW);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_status <= '0;
			irq_mask <= '0;
			irq <= 1'b0;
		end
		else
		begin
			if (acc && !pwrite && paddr == i2c_scs_pkg::ADDR_IRQ)
				irq_status <= ev;
			else
				irq_status <= irq_status | ev;
			if (acc && pwrite && paddr == i2c_scs_pkg::ADDR_MASK)
				irq_mask <= pwdata[IRQ_HI:0];
			irq <= |(irq_status & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB answer
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= setup;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (setup)
			begin
				unique case (paddr)
					i2c_scs_pkg::ADDR_PRESC:
						prdata[7:0] <= prescaler_register;
					i2c_scs_pkg::ADDR_SHIFT:
						prdata[7:0] <= shift_data;
					i2c_scs_pkg::ADDR_CTRL:
					begin
						prdata[i2c_scs_pkg::CTRL_START] <= start_trigger;
						prdata[i2c_scs_pkg::CTRL_STOP] <= stop_trigger;
						prdata[i2c_scs_pkg::CTRL_ENABLE] <= operation_enable;
						prdata[i2c_scs_pkg::CTRL_RSV_DIS] <= reservation_disable;
					end
					i2c_scs_pkg::ADDR_FLAG:
					begin
						prdata[i2c_scs_pkg::FLAG_STCF] <= start_clear_flag;
						prdata[i2c_scs_pkg::FLAG_BUSY] <= bus_busy;
						prdata[i2c_scs_pkg::FLAG_WAIT] <=
							state == i2c_scs_pkg::ST_WAIT;
						prdata[i2c_scs_pkg::FLAG_MASTER] <=
							state != i2c_scs_pkg::ST_IDLE;
					end
					i2c_scs_pkg::ADDR_IRQ:
						prdata[IRQ_HI:0] <= irq_status | ev;
					i2c_scs_pkg::ADDR_MASK:
						prdata[IRQ_HI:0] <= irq_mask;
					default:
						pslverr <= 1'b1;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	start_lines_a: assert property (
		state == i2c_scs_pkg::ST_START_HOLD
		##1 state == i2c_scs_pkg::ST_START_HOLD
		|-> !bus_data_line_oe_b && bus_clock_line_oe_b)
		else $error("start hold lines wrong");
	reserve_wait_a: assert property (
		state == i2c_scs_pkg::ST_IDLE && start_trigger && bus_busy
		&& operation_enable && !exit_wr && !en_fall
		|=> state == i2c_scs_pkg::ST_IDLE && start_trigger)
		else $error("reserved start not held");
	deny_flag_a: assert property (
		deny |=> start_clear_flag && !start_trigger
		##1 state == i2c_scs_pkg::ST_IDLE)
		else $error("refused start not flagged");
	restart_go_a: assert property (
		state == i2c_scs_pkg::ST_WAIT && start_trigger
		&& operation_enable && !exit_wr && !en_fall
		|=> state == i2c_scs_pkg::ST_RESTART_LOW)
		else $error("no repeated start from wait");
	set_once_a: assert property (
		ctl_wr && start_trigger && pwdata[i2c_scs_pkg::CTRL_START]
		&& !hold_done && !exit_wr && !en_fall
		|=> start_trigger && $stable(start_clear_flag))
		else $error("second start write acted");
	auto_clear_a: assert property (
		hold_done |=> !start_trigger
		&& state != i2c_scs_pkg::ST_START_HOLD)
		else $error("start trigger not cleared after start");
	exit_clear_a: assert property (
		exit_wr || en_fall |=> !start_trigger
		&& state == i2c_scs_pkg::ST_IDLE)
		else $error("exit or disable left start pending");
	wait_release_a: assert property (
		state == i2c_scs_pkg::ST_WAIT
		&& sh_wr && !start_trigger && operation_enable && !exit_wr
		|=> state == i2c_scs_pkg::ST_SHIFT_LOW ##1 bit_cnt == 3'h0)
		else $error("shift write did not end wait");
	presc_zero_a: assert property (
		setup && paddr == i2c_scs_pkg::ADDR_PRESC
		|=> prdata[7:5] == 3'h0 && !prdata[2])
		else $error("reserved prescaler bits read nonzero");
	div_match_a: assert property (
		$rose(tick) ##1 !tick |->
		!prescaler_register[i2c_scs_pkg::PRESC_EN_BIT]
		|| i2c_scs_pkg::div_last(prescaler_register[3],
		prescaler_register[1:0]) != 3'h0 || $changed(prescaler_register))
		else $error("undivided clock missed a tick");

	start_seen_c: cover property (hold_done);
	byte_seen_c: cover property (byte_done);
	deny_seen_c: cover property (deny);
	restart_seen_c: cover property (state == i2c_scs_pkg::ST_RESTART_HIGH);
endmodule : i2c_start_clock_shift
`default_nettype wire

// *** testbench/i2c_bus_partner.sv ***
/*
 * Other party on the two-wire bus: start, stop and a slave byte.
 * Assumes wired-and lines with pull-ups; oe_b low pulls a line low.
 */
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_partner (
	// Clock
	input wire logic clk_sys,
	// Line levels
	input wire logic scl,
	input wire logic sda,
	// Pulls
	output logic sda_oe_b,
	output logic scl_oe_b,
	// Bits seen
	output logic [7:0] rx
);
	logic [7:0] tx;
	logic slave_en;
	initial
	begin
		sda_oe_b = 1'b1;
		scl_oe_b = 1'b1;
		rx = 8'h00;
		tx = 8'hFF;
		slave_en = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// Sample at rising clock
	always @(posedge scl)
		rx <= {rx[6:0], sda};
	// Slave data moves while clock low, MSB first
	always @(negedge scl)
		if (slave_en)
		begin
			sda_oe_b <= tx[7];
			tx <= {tx[6:0], 1'b1};
		end
	task serve(input logic en, input logic [7:0] b);
		slave_en = en;
		tx = b;
		sda_oe_b = 1'b1;
	endtask : serve
	// Data falls with clock high: bus taken
	task bus_start;
		@(posedge clk_sys);
		sda_oe_b <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask : bus_start
	task bus_stop;
		@(posedge clk_sys);
		sda_oe_b <= 1'b1;
	endtask : bus_stop
endmodule : i2c_bus_partner
`default_nettype wire

// *** testbench/tb.sv ***
/*
 * Bench for the I2C start, division clock and shift block.
 * Assumes an APB master here and one other party on the bus.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdata;
	logic pready, pslverr, irq, so, soe, co, coe, psoe, pcoe, rerr;
	logic [7:0] prx;
	logic [7:0] pat;
	int err_count = 0;
	int checks_done = 0;
	int i, c;
	wire sda = (soe | so) & psoe;
	wire scl = (coe | co) & pcoe;
	always #50 clk_sys = ~clk_sys;
	i2c_start_clock_shift dut (.clk_sys(clk_sys), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_data_line_i(sda), .bus_data_line_o(so),
		.bus_data_line_oe_b(soe), .bus_clock_line_i(scl),
		.bus_clock_line_o(co), .bus_clock_line_oe_b(coe), .irq(irq));
	i2c_bus_partner peer (.clk_sys(clk_sys), .scl(scl), .sda(sda),
		.sda_oe_b(psoe), .scl_oe_b(pcoe), .rx(prx));
	////////////////////////////////////////////////////////////////////////
	task final_report;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	task fail(input string m);
		err_count++;
		$display("ERROR %0t: %s", $time, m);
	endtask : fail
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
			fail($sformatf("got %h expected %h", got, exp));
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k >= 20)
		begin
			fail("no pready");
			final_report;
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task flag(input int b, input logic v);
		int k;
		k = 0;
		do
		begin
			rd(i2c_scs_pkg::ADDR_FLAG);
			k++;
		end
		while (rdata[b] !== v && k < 3000);
		if (k >= 3000)
		begin
			fail("flag timeout");
			final_report;
		end
	endtask : flag
	// Start: data falls with clock high, then clock low and wait
	task start_on(input logic [31:0] d);
		int k;
		if (d != 0)
			apb(1'b1, i2c_scs_pkg::ADDR_CTRL, d);
		for (k = 0; k < 900 && sda !== 1'b1; k++) @(posedge clk_sys);
		for (k = 0; k < 900 && sda !== 1'b0; k++) @(posedge clk_sys);
		chk(scl, 1'b1);
		flag(i2c_scs_pkg::FLAG_WAIT, 1'b1);
		chk(scl, 1'b0);
		rd(i2c_scs_pkg::ADDR_CTRL);
		chk(rdata[0], 1'b0);
	endtask : start_on
	task stop_idle;
		apb(1'b1, i2c_scs_pkg::ADDR_CTRL, 32'h0A);
		flag(i2c_scs_pkg::FLAG_MASTER, 1'b0);
	endtask : stop_idle
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(i2c_scs_pkg::ADDR_PRESC);
		chk(rdata, 32'h0);
		rd(i2c_scs_pkg::ADDR_SHIFT);
		chk(rdata, 32'h0);
		apb(1'b1, i2c_scs_pkg::ADDR_PRESC, 32'hFF);
		rd(i2c_scs_pkg::ADDR_PRESC);
		chk(rdata, 32'h1B);
		rd(8'h18);
		chk(rerr, 1'b1);
		$display("test registers done");
		apb(1'b1, i2c_scs_pkg::ADDR_PRESC, 32'h03);
		apb(1'b1, i2c_scs_pkg::ADDR_MASK, 32'h07);
		apb(1'b1, i2c_scs_pkg::ADDR_CTRL, 32'h09);
		repeat (100) @(posedge clk_sys);
		chk(sda, 1'b0);
		chk(scl, 1'b1);
		chk(irq, 1'b0);
		apb(1'b1, i2c_scs_pkg::ADDR_CTRL, 32'h0C);
		rd(i2c_scs_pkg::ADDR_CTRL);
		chk(rdata[0], 1'b0);
		$display("test division stop done");
		for (i = 0; i < 5; i++)
		begin
			pat = 8'hA5 + 8'(i * 17);
			apb(1'b1, i2c_scs_pkg::ADDR_PRESC, (i < 4) ? 32'h10 + i : 32'h1B);
			start_on(32'h09);
			chk(irq, 1'b1);
			rd(i2c_scs_pkg::ADDR_IRQ);
			chk(rdata[0], 1'b1);
			apb(1'b1, i2c_scs_pkg::ADDR_SHIFT, {24'h0, pat});
			for (c = 0; c < 900 && scl !== 1'b1; c++) @(posedge clk_sys);
			c = 0;
			while (scl === 1'b1 && c < 200)
			begin
				@(posedge clk_sys);
				c++;
			end
			chk(c, (i < 4) ? 4 * (i + 2) : 4);
			flag(i2c_scs_pkg::FLAG_WAIT, 1'b1);
			chk(prx, pat);
			stop_idle();
		end
		apb(1'b1, i2c_scs_pkg::ADDR_CTRL, 32'h09);
		apb(1'b1, i2c_scs_pkg::ADDR_SHIFT, 32'h5A);
		for (c = 0; c < 900 && prx !== 8'h5A; c++) @(posedge clk_sys);
		chk(prx, 8'h5A);
		flag(i2c_scs_pkg::FLAG_WAIT, 1'b1);
		stop_idle();
		$display("test division and transmit done");
		peer.serve(1'b1, 8'h3C);
		start_on(32'h09);
		apb(1'b1, i2c_scs_pkg::ADDR_SHIFT, 32'hFF);
		flag(i2c_scs_pkg::FLAG_WAIT, 1'b1);
		peer.serve(1'b0, 8'hFF);
		rd(i2c_scs_pkg::ADDR_SHIFT);
		chk(rdata, 32'h3C);
		rd(i2c_scs_pkg::ADDR_IRQ);
		start_on(32'h09);
		rd(i2c_scs_pkg::ADDR_IRQ);
		chk(rdata[0], 1'b1);
		stop_idle();
		$display("test receive and restart done");
		peer.bus_start();
		apb(1'b1, i2c_scs_pkg::ADDR_CTRL, 32'h18);
		apb(1'b1, i2c_scs_pkg::ADDR_CTRL, 32'h19);
		rd(i2c_scs_pkg::ADDR_FLAG);
		chk(rdata[i2c_scs_pkg::FLAG_STCF], 1'b1);
		rd(i2c_scs_pkg::ADDR_CTRL);
		chk(rdata[0], 1'b0);
		apb(1'b1, i2c_scs_pkg::ADDR_CTRL, 32'h08);
		apb(1'b1, i2c_scs_pkg::ADDR_CTRL, 32'h09);
		apb(1'b1, i2c_scs_pkg::ADDR_CTRL, 32'h09);
		rd(i2c_scs_pkg::ADDR_CTRL);
		chk(rdata[0], 1'b1);
		peer.bus_stop();
		start_on(32'h0);
		stop_idle();
		peer.bus_start();
		apb(1'b1, i2c_scs_pkg::ADDR_CTRL, 32'h09);
		apb(1'b1, i2c_scs_pkg::ADDR_CTRL, 32'h00);
		rd(i2c_scs_pkg::ADDR_CTRL);
		chk(rdata[0], 1'b0);
		peer.bus_stop();
		$display("test reservation done");
		final_report;
	end
endmodule : tb
`default_nettype wire
